// *** src/spi_stat_defs.svh ***
// register offsets, field positions and reset values of the serial port status block
// assumes inclusion from design files only
`ifndef SPI_STAT_DEFS_SVH
`define SPI_STAT_DEFS_SVH
`define OFF_DMA_CTRL     6'h1C
`define OFF_INT_FLAGS    6'h20
`define OFF_INT_EN       6'h24
`define OFF_WAKE_FLAGS   6'h28
`define OFF_WAKE_EN      6'h2C
`define OFF_ACT_STATUS   6'h30
`define OFF_PORT_CTRL    6'h34
`define POS_RX_DMA_EN    31
`define POS_RX_FIFO_EN   22
`define POS_TX_DMA_EN    15
`define POS_TX_FLUSH     7
`define POS_TX_FIFO_EN   6
`define POS_MASTER_SEL   1
`define POS_MULTI_MASTER 2
`define RST_TX_LEVEL     5'h10
`define RST_INT_FLAGS    16'h0002
`define INT_IMPL_MASK    16'hFB3F
`define FIFO_DEPTH       6'h20
`define RX_LEVEL_MAX     5'h1E
`endif

// *** src/spi_stat_pkg.sv ***
// types shared by the serial port status block
// assumes nothing of its surroundings
package spi_stat_pkg;
  typedef struct packed {
    logic [5:0] rx_cnt;
    logic [5:0] tx_cnt;
    logic       rx_read_empty;
    logic       tx_write_full;
    logic       rx_char_done;
    logic       tx_fetch_empty;
    logic       collision;
    logic       xfer_start;
    logic       xfer_last_done;
  } engine_evt_t;
  typedef enum logic [1:0] {IDLE, ACTIVE, DONE} busy_state_t;
endpackage

// *** src/spi_fifo_dma_irq_status.sv ***
// status, interrupt, wakeup and dma request logic of the serial port
// assumes a shift engine on i_clk reporting queue counts and event pulses
`timescale 1ns/1ns
`default_nettype none
`include "spi_stat_defs.svh"
module spi_fifo_dma_irq_status (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic [5:0]                i_addr,
  input  wire logic [31:0]               i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic [31:0]                    o_rdata,
  input  wire spi_stat_pkg::engine_evt_t i_evt,
  input  wire logic                      i_ss_pin,
  input  wire logic                      i_sclk_pin,
  output logic                           o_rx_dma_req,
  output logic                           o_tx_dma_req,
  output logic                           o_irq,
  output logic                           o_wakeup,
  output logic                           o_tx_flush,
  output logic                           o_tx_fifo_en,
  output logic                           o_rx_fifo_en,
  output logic                           o_master_select_bit,
  output logic                           o_sclk_stall
);
  //////////////////////////////////////////////////////////////////////////////
  logic        rx_dma_en_ff, rx_fifo_en_ff, tx_dma_en_ff, tx_fifo_en_ff;
  logic [4:0]  rx_level_ff, tx_level_ff;
  logic [15:0] int_fl_ff, int_en_ff;
  logic [3:0]  wake_fl_ff, wake_en_ff;
  logic        master_ff, multi_ff;
  logic [2:0]  ss_sync_ff, sclk_sync_ff;
  logic [4:0]  bit_cnt_ff;
  spi_stat_pkg::busy_state_t busy_st_ff, nxt_busy_st;
  logic        rx_req_ff, tx_req_ff, irq_ff, wake_ff, flush_ff, stall_ff;
  logic [31:0] rdata_ff;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = (a == off);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  wire wr_dma   = i_wr && hit(i_addr, `OFF_DMA_CTRL);
  wire wr_intfl = i_wr && hit(i_addr, `OFF_INT_FLAGS);
  wire wr_inten = i_wr && hit(i_addr, `OFF_INT_EN);
  wire wr_wkfl  = i_wr && hit(i_addr, `OFF_WAKE_FLAGS);
  wire wr_wken  = i_wr && hit(i_addr, `OFF_WAKE_EN);
  wire wr_port  = i_wr && hit(i_addr, `OFF_PORT_CTRL);
  // ss is active low on the pin; sync stage 0 is read only by stage 1
  wire ss_act   = ~ss_sync_ff[1];
  wire ss_rise  = ss_act && ss_sync_ff[2];        // became asserted
  wire ss_fall  = ~ss_act && ~ss_sync_ff[2];      // became deasserted
  wire sclk_edge = sclk_sync_ff[1] && ~sclk_sync_ff[2];
  wire slave    = ~master_ff;
  wire flush    = wr_dma && i_wdata[`POS_TX_FLUSH];
  wire [5:0] tx_cnt = flush ? 6'h00 : i_evt.tx_cnt;
  wire rx_over  = i_evt.rx_cnt > {1'b0, rx_level_ff};
  wire tx_under = tx_cnt < {1'b0, tx_level_ff};
  wire rx_full  = i_evt.rx_cnt == `FIFO_DEPTH;
  wire tx_empty = tx_cnt == 6'h00;
  wire abort_c  = slave && ss_fall && (bit_cnt_ff != 5'h00);
  wire fault_c  = master_ff && multi_ff && ss_rise;
  wire [15:0] set_v = {i_evt.rx_read_empty,
                       slave && i_evt.rx_char_done && rx_full,
                       slave && i_evt.tx_fetch_empty,
                       i_evt.tx_write_full,
                       master_ff && busy_st_ff == spi_stat_pkg::DONE,
                       1'b0, abort_c,
                       fault_c || i_evt.collision,
                       2'b00, ss_fall, ss_rise,
                       rx_full, rx_over, tx_empty, tx_under};
  wire [15:0] clr_v = (wr_intfl ? i_wdata[15:0] : 16'h0000)
                    | (flush ? 16'h3003 : 16'h0000);
  // set wins over clear
  wire [15:0] nxt_int_fl = ((int_fl_ff & ~clr_v) | set_v) & `INT_IMPL_MASK;
  wire [3:0]  wake_set = {rx_full, rx_over, tx_empty, tx_under};
  wire [3:0]  nxt_wake_fl = (wake_fl_ff & ~(wr_wkfl ? i_wdata[3:0] : 4'h0)) | wake_set;
  wire        nxt_rx_req = rx_dma_en_ff && rx_over;
  wire        nxt_tx_req = tx_dma_en_ff && tx_fifo_en_ff && tx_under;
  wire        nxt_irq    = |(nxt_int_fl & int_en_ff);
  wire        nxt_wake   = |(nxt_wake_fl & wake_en_ff);
  wire        nxt_stall  = master_ff && ((i_evt.rx_char_done && rx_full)
                           || i_evt.tx_fetch_empty);
  wire [31:0] dma_rd = {rx_dma_en_ff, 1'b0, i_evt.rx_cnt, 1'b0, rx_fifo_en_ff, 1'b0,
                        rx_level_ff, tx_dma_en_ff, 1'b0, i_evt.tx_cnt,
                        1'b0, tx_fifo_en_ff, 1'b0, tx_level_ff};
  wire        busy = busy_st_ff != spi_stat_pkg::IDLE;
  wire [31:0] nxt_rdata =
      !i_rd                               ? 32'h0000_0000 :
      hit(i_addr, `OFF_DMA_CTRL)          ? dma_rd :
      hit(i_addr, `OFF_INT_FLAGS)         ? {16'h0000, int_fl_ff} :
      hit(i_addr, `OFF_INT_EN)            ? {16'h0000, int_en_ff} :
      hit(i_addr, `OFF_WAKE_FLAGS)        ? {28'h0, wake_fl_ff} :
      hit(i_addr, `OFF_WAKE_EN)           ? {28'h0, wake_en_ff} :
      hit(i_addr, `OFF_ACT_STATUS)        ? {31'h0, busy} :
      hit(i_addr, `OFF_PORT_CTRL)         ? {29'h0, multi_ff, master_ff, 1'b0} :
                                            32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////////
  // busy: master from start to last character, slave while selected
  always_comb begin
    nxt_busy_st = busy_st_ff;
    case (busy_st_ff)
      spi_stat_pkg::IDLE: begin
        if (master_ff ? i_evt.xfer_start : ss_rise) begin
          nxt_busy_st = spi_stat_pkg::ACTIVE;
        end
      end
      spi_stat_pkg::ACTIVE: begin
        if (master_ff ? i_evt.xfer_last_done : ss_fall) begin
          nxt_busy_st = master_ff ? spi_stat_pkg::DONE : spi_stat_pkg::IDLE;
        end
      end
      default: begin
        nxt_busy_st = spi_stat_pkg::IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ss_sync_ff   <= 3'h7;
      sclk_sync_ff <= 3'h0;
    end else begin
      ss_sync_ff   <= {ss_sync_ff[1:0], i_ss_pin};
      sclk_sync_ff <= {sclk_sync_ff[1:0], i_sclk_pin};
    end
  end

  // sclk edges within a selected slave character
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !ss_act || i_evt.rx_char_done) begin
      bit_cnt_ff <= 5'h00;
    end else if (sclk_edge && bit_cnt_ff != 5'h1F) begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_dma_en_ff  <= 1'b0;
      rx_fifo_en_ff <= 1'b0;
      tx_dma_en_ff  <= 1'b0;
      tx_fifo_en_ff <= 1'b0;
      rx_level_ff   <= 5'h00;
      tx_level_ff   <= `RST_TX_LEVEL;
    end else if (wr_dma) begin
      rx_dma_en_ff  <= i_wdata[`POS_RX_DMA_EN];
      rx_fifo_en_ff <= i_wdata[`POS_RX_FIFO_EN];
      tx_dma_en_ff  <= i_wdata[`POS_TX_DMA_EN];
      tx_fifo_en_ff <= i_wdata[`POS_TX_FIFO_EN];
      // 0x1F is not legal; clamp to the top legal level
      rx_level_ff   <= (i_wdata[20:16] > `RX_LEVEL_MAX) ? `RX_LEVEL_MAX : i_wdata[20:16];
      tx_level_ff   <= i_wdata[4:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      int_fl_ff  <= `RST_INT_FLAGS;
      int_en_ff  <= 16'h0000;
      wake_fl_ff <= 4'h0;
      wake_en_ff <= 4'h0;
      master_ff  <= 1'b0;
      multi_ff   <= 1'b0;
      busy_st_ff <= spi_stat_pkg::IDLE;
    end else begin
      int_fl_ff  <= nxt_int_fl;
      wake_fl_ff <= nxt_wake_fl;
      busy_st_ff <= nxt_busy_st;
      if (wr_inten) begin
        int_en_ff <= i_wdata[15:0] & `INT_IMPL_MASK;
      end
      if (wr_wken) begin
        wake_en_ff <= i_wdata[3:0];
      end
      if (wr_port) begin
        master_ff <= i_wdata[`POS_MASTER_SEL];
        multi_ff  <= i_wdata[`POS_MULTI_MASTER];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_req_ff <= 1'b0;
      tx_req_ff <= 1'b0;
      irq_ff    <= 1'b0;
      wake_ff   <= 1'b0;
      flush_ff  <= 1'b0;
      stall_ff  <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      rx_req_ff <= nxt_rx_req;
      tx_req_ff <= nxt_tx_req;
      irq_ff    <= nxt_irq;
      wake_ff   <= nxt_wake;
      flush_ff  <= flush;
      stall_ff  <= nxt_stall ? 1'b1 : (stall_ff && master_ff && (rx_full || tx_empty));
      rdata_ff  <= nxt_rdata;
    end
  end

  assign o_rx_dma_req        = rx_req_ff;
  assign o_tx_dma_req        = tx_req_ff;
  assign o_irq               = irq_ff;
  assign o_wakeup            = wake_ff;
  assign o_tx_flush          = flush_ff;
  assign o_tx_fifo_en        = tx_fifo_en_ff;
  assign o_rx_fifo_en        = rx_fifo_en_ff;
  assign o_master_select_bit = master_ff;
  assign o_sclk_stall        = stall_ff;
  assign o_rdata             = rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // single-cycle conditions and one two-step sequence that the properties below build on
  sequence s_flush_wr;
    wr_dma && i_wdata[`POS_TX_FLUSH];
  endsequence
  sequence s_flags_gone;
    int_fl_ff[13:12] == 2'b00;
  endsequence
  sequence s_last_char;
    master_ff && busy_st_ff == spi_stat_pkg::ACTIVE && i_evt.xfer_last_done && !wr_port;
  endsequence
  sequence s_done_flag;
    ##1 busy_st_ff == spi_stat_pkg::DONE ##1 int_fl_ff[11];
  endsequence
  sequence s_sel_start;
    !master_ff && busy_st_ff == spi_stat_pkg::IDLE && ss_rise;
  endsequence
  sequence s_sel_end;
    !master_ff && busy_st_ff == spi_stat_pkg::ACTIVE && ss_fall;
  endsequence

  // dma requests and queue levels
  rx_dma_req_a: assert property (
      rx_dma_en_ff && i_evt.rx_cnt > {1'b0, rx_level_ff} |=> o_rx_dma_req)
      else $error("rx dma request missing");
  rx_dma_off_a: assert property (
      !rx_dma_en_ff |=> !o_rx_dma_req)
      else $error("rx dma request while disabled");
  rx_level_flag_a: assert property (
      i_evt.rx_cnt > {1'b0, rx_level_ff} |=> int_fl_ff[2])
      else $error("rx level flag missing");
  rx_level_legal_a: assert property (
      rx_level_ff != 5'h1F)
      else $error("rx threshold holds an illegal value");
  tx_dma_off_a: assert property (
      !tx_dma_en_ff |=> !o_tx_dma_req)
      else $error("tx dma request while disabled");
  tx_cnt_read_a: assert property (
      i_rd && hit(i_addr, `OFF_DMA_CTRL) |=> o_rdata[13:8] == $past(i_evt.tx_cnt))
      else $error("tx count wrong");
  tx_flush_a: assert property (
      s_flush_wr |=> o_tx_flush)
      else $error("flush not issued");
  tx_flush_clr_a: assert property (
      s_flush_wr ##0 (!i_evt.tx_write_full && !i_evt.tx_fetch_empty) |=> s_flags_gone)
      else $error("flush left tx error flags");
  tx_fifo_off_a: assert property (
      !tx_fifo_en_ff |=> !o_tx_dma_req)
      else $error("tx request with queue off");
  tx_dma_req_a: assert property (
      tx_dma_en_ff && tx_fifo_en_ff && i_evt.tx_cnt < {1'b0, tx_level_ff} |=> o_tx_dma_req)
      else $error("tx dma request missing");
  tx_level_flag_a: assert property (
      tx_cnt < {1'b0, tx_level_ff} |=> int_fl_ff[0])
      else $error("tx level flag missing");

  // error and event flags and the master stall
  rx_und_flag_a: assert property (
      i_evt.rx_read_empty |=> int_fl_ff[15])
      else $error("rx underrun flag missing");
  rx_ovr_slave_a: assert property (
      !master_ff && i_evt.rx_char_done && i_evt.rx_cnt == `FIFO_DEPTH |=> int_fl_ff[14])
      else $error("rx overrun flag missing");
  rx_ovr_master_a: assert property (
      master_ff && i_evt.rx_char_done && i_evt.rx_cnt == `FIFO_DEPTH |=> o_sclk_stall)
      else $error("master did not stall on full rx");
  tx_und_slave_a: assert property (
      !master_ff && i_evt.tx_fetch_empty |=> int_fl_ff[13])
      else $error("tx underrun flag missing");
  tx_stall_a: assert property (
      master_ff && i_evt.tx_fetch_empty |=> o_sclk_stall)
      else $error("master did not stall on empty tx");
  tx_ovr_flag_a: assert property (
      i_evt.tx_write_full |=> int_fl_ff[12])
      else $error("tx overrun flag missing");
  m_done_flag_a: assert property (
      s_last_char |-> s_done_flag)
      else $error("master done flag missing");
  abort_flag_a: assert property (
      !master_ff && ss_fall && bit_cnt_ff != 5'h00 |=> int_fl_ff[9])
      else $error("abort flag missing");
  fault_flag_a: assert property (
      master_ff && multi_ff && ss_rise |=> int_fl_ff[8])
      else $error("fault flag missing");
  collision_flag_a: assert property (
      i_evt.collision |=> int_fl_ff[8])
      else $error("collision did not set fault");
  ss_event_a: assert property (
      ss_rise |=> int_fl_ff[4])
      else $error("select assert flag missing");
  ss_deassert_a: assert property (
      ss_fall |=> int_fl_ff[5])
      else $error("select deassert flag missing");

  // interrupt and wakeup gating
  irq_gate_a: assert property (
      int_en_ff == 16'h0000 |=> !o_irq)
      else $error("irq while all enables off");
  irq_raise_a: assert property (
      (int_fl_ff & int_en_ff) != 16'h0000 && !wr_intfl && !wr_inten && !wr_dma |=> o_irq)
      else $error("irq missing for enabled flag");
  wake_flag_a: assert property (
      i_evt.rx_cnt == `FIFO_DEPTH |=> wake_fl_ff[3])
      else $error("rx full wake flag missing");
  wake_clr_a: assert property (
      wr_wkfl && i_wdata[2] && !(i_evt.rx_cnt > {1'b0, rx_level_ff}) |=> !wake_fl_ff[2])
      else $error("wake flag not cleared");
  wake_gate_a: assert property (
      wake_en_ff == 4'h0 |=> !o_wakeup)
      else $error("wakeup while disabled");
  wake_raise_a: assert property (
      (wake_fl_ff & wake_en_ff) != 4'h0 && !wr_wkfl && !wr_wken |=> o_wakeup)
      else $error("wakeup missing for enabled flag");

  // busy, mode bit and write-one-to-clear
  busy_master_a: assert property (
      master_ff && busy_st_ff == spi_stat_pkg::IDLE && i_evt.xfer_start
      |=> busy_st_ff == spi_stat_pkg::ACTIVE) else $error("master busy did not rise");
  busy_slave_a: assert property (
      s_sel_start |=> busy_st_ff == spi_stat_pkg::ACTIVE)
      else $error("slave busy did not rise");
  busy_slave_end_a: assert property (
      s_sel_end |=> busy_st_ff == spi_stat_pkg::IDLE)
      else $error("slave busy did not fall");
  master_no_und_a: assert property (
      master_ff && int_fl_ff[14:13] == 2'b00 |=> int_fl_ff[14:13] == 2'b00)
      else $error("slave-only flag set in master");
  tx_empty_flag_a: assert property (
      i_evt.tx_cnt == 6'h00 |=> int_fl_ff[1])
      else $error("tx empty flag missing");
  rx_full_flag_a: assert property (
      i_evt.rx_cnt == `FIFO_DEPTH |=> int_fl_ff[3])
      else $error("rx full flag missing");
  w1c_set_wins_a: assert property (
      wr_intfl && i_wdata[12] && i_evt.tx_write_full |=> int_fl_ff[12])
      else $error("set lost to clear");
  w1c_clear_a: assert property (
      wr_intfl && i_wdata[15] && !i_evt.rx_read_empty |=> !int_fl_ff[15])
      else $error("flag not cleared by write one");
endmodule
`default_nettype wire

// *** verif/spi_far_master.sv ***
// far-side serial master that drives the select and clock pins
// assumes the bench calls frame in slave mode, and once in multi-master mode to raise the fault flag
`timescale 1ns/1ns
`default_nettype none
module spi_far_master (
  output logic o_ss_n,
  output logic o_sclk
);
  // select is driven high, clock stands low between frames
  initial begin
    o_ss_n = 1'b1;
    o_sclk = 1'b0;
  end
  // 80 ns clock periods inside one select window
  task automatic frame(input int n);
    o_ss_n = 1'b0;
    #40;
    repeat (n) begin
      o_sclk = 1'b1;
      #40;
      o_sclk = 1'b0;
      #40;
    end
    o_ss_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** verif/spi_fifo_dma_irq_status_tb.sv ***
// self-checking bench for the serial port status block
// assumes the far-side master model and the shared package
`timescale 1ns/1ns
`default_nettype none
module spi_fifo_dma_irq_status_tb;
  logic                      i_clk   = 1'b0;
  logic                      i_rst_n = 1'b0;
  logic [5:0]                i_addr  = 6'h00;
  logic [31:0]               i_wdata = 32'h0;
  logic                      i_wr    = 1'b0;
  logic                      i_rd    = 1'b0;
  spi_stat_pkg::engine_evt_t i_evt   = '{tx_cnt: 6'h10, default: '0};
  logic [31:0]               o_rdata;
  logic [31:0]               rv;
  logic                      o_rx_dma_req, o_tx_dma_req, o_irq, o_wakeup, o_tx_flush;
  logic                      o_tx_fifo_en, o_rx_fifo_en, o_master_select_bit, o_sclk_stall;
  logic                      ss_n, sclk;
  int                        n_errors  = 0;
  int                        cmp_count = 0;
  always #5 i_clk = ~i_clk;
  spi_fifo_dma_irq_status u_spi_fifo_dma_irq_status (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_evt(i_evt),
    .i_ss_pin(ss_n), .i_sclk_pin(sclk), .o_rx_dma_req(o_rx_dma_req),
    .o_tx_dma_req(o_tx_dma_req), .o_irq(o_irq), .o_wakeup(o_wakeup),
    .o_tx_flush(o_tx_flush), .o_tx_fifo_en(o_tx_fifo_en), .o_rx_fifo_en(o_rx_fifo_en),
    .o_master_select_bit(o_master_select_bit), .o_sclk_stall(o_sclk_stall));
  spi_far_master u_spi_far_master (.o_ss_n(ss_n), .o_sclk(sclk));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    step(1);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    step(1);
    i_rd <= 1'b0;
    rv = o_rdata;
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // b is the packed position of a one-cycle event pulse
  task automatic ev(input int b);
    i_evt[b] <= 1'b1;
    step(1);
    i_evt[b] <= 1'b0;
    step(2);
  endtask
  task automatic finish_test;
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(6'h1C);
    chk("dma", rv, 32'h00001010);
    rd(6'h20);
    chk("iflg", rv, 32'h00000002);
    rd(6'h24);
    chk("ien", rv, 32'h0);
    rd(6'h2C);
    chk("wen", rv, 32'h0);
    rd(6'h30);
    chk("stat", rv, 32'h0);
    rd(6'h3C);
    chk("unmap", rv, 32'h0);
    chk("txen", 32'(o_tx_fifo_en), 32'h0);
  endtask
  task automatic t_tx;
    wr(6'h1C, 32'h00008044);
    i_evt.tx_cnt <= 6'h03;
    step(3);
    chk("txdma", 32'(o_tx_dma_req), 32'h1);
    chk("txen", 32'(o_tx_fifo_en), 32'h1);
    rd(6'h1C);
    chk("txcnt", rv & 32'h00003F00, 32'h00000300);
    rd(6'h20);
    chk("txlvl", rv & 32'h1, 32'h1);
    i_evt.tx_cnt <= 6'h04;
    step(3);
    chk("txdma", 32'(o_tx_dma_req), 32'h0);
    i_evt.tx_cnt <= 6'h03;
    step(3);
    wr(6'h1C, 32'h00000044);
    step(2);
    chk("txdma", 32'(o_tx_dma_req), 32'h0);
    wr(6'h1C, 32'h000000C4);
    chk("flush", 32'(o_tx_flush), 32'h1);
    wr(6'h1C, 32'h00000004);
    chk("flush", 32'(o_tx_flush), 32'h0);
    i_evt.tx_cnt <= 6'h10;
    step(2);
    chk("txen", 32'(o_tx_fifo_en), 32'h0);
    wr(6'h20, 32'h00000001);
    rd(6'h20);
    chk("txlvl", rv & 32'h1, 32'h0);
  endtask
  task automatic t_rx;
    wr(6'h1C, 32'h80420010);
    i_evt.rx_cnt <= 6'h03;
    step(3);
    chk("rxdma", 32'(o_rx_dma_req), 32'h1);
    chk("rxen", 32'(o_rx_fifo_en), 32'h1);
    rd(6'h20);
    chk("rxlvl", rv & 32'h4, 32'h4);
    rd(6'h28);
    chk("wflg", rv & 32'h4, 32'h4);
    chk("wake", 32'(o_wakeup), 32'h0);
    wr(6'h2C, 32'h00000004);
    step(2);
    chk("wake", 32'(o_wakeup), 32'h1);
    i_evt.rx_cnt <= 6'h02;
    step(3);
    chk("rxdma", 32'(o_rx_dma_req), 32'h0);
    wr(6'h28, 32'h00000004);
    step(2);
    chk("wake", 32'(o_wakeup), 32'h0);
    wr(6'h1C, 32'h001F0010);
    rd(6'h1C);
    chk("rxlim", rv & 32'h001F0000, 32'h001E0000);
    wr(6'h2C, 32'h0);
    wr(6'h20, 32'h00000004);
  endtask
  task automatic t_err;
    ev(6);
    ev(5);
    ev(3);
    ev(2);
    i_evt.rx_cnt <= 6'h20;
    ev(4);
    rd(6'h20);
    chk("errs", rv & 32'h0000F108, 32'h0000F108);
    chk("irq", 32'(o_irq), 32'h0);
    wr(6'h24, 32'h00008000);
    step(2);
    chk("irq", 32'(o_irq), 32'h1);
    i_evt.rx_cnt <= 6'h00;
    wr(6'h20, 32'h0000F10C);
    step(2);
    chk("irq", 32'(o_irq), 32'h0);
    rd(6'h20);
    chk("clr", rv & 32'h0000F10C, 32'h0);
    wr(6'h24, 32'h0);
  endtask
  task automatic t_master;
    wr(6'h34, 32'h00000002);
    step(1);
    chk("msel", 32'(o_master_select_bit), 32'h1);
    ev(1);
    rd(6'h30);
    chk("busy", rv, 32'h1);
    ev(0);
    rd(6'h30);
    chk("busy", rv, 32'h0);
    rd(6'h20);
    chk("mdone", rv & 32'h800, 32'h800);
    i_evt.tx_cnt <= 6'h00;
    ev(3);
    chk("stall", 32'(o_sclk_stall), 32'h1);
    rd(6'h20);
    chk("txund", rv & 32'h2000, 32'h0);
    i_evt.tx_cnt <= 6'h10;
    step(3);
    chk("stall", 32'(o_sclk_stall), 32'h0);
    i_evt.rx_cnt <= 6'h20;
    ev(4);
    chk("stall", 32'(o_sclk_stall), 32'h1);
    rd(6'h20);
    chk("rxovr", rv & 32'h4000, 32'h0);
    i_evt.rx_cnt <= 6'h00;
    step(3);
    chk("stall", 32'(o_sclk_stall), 32'h0);
    wr(6'h34, 32'h00000006);
    u_spi_far_master.frame(1);
    step(4);
    rd(6'h20);
    chk("fault", rv & 32'h100, 32'h100);
    wr(6'h34, 32'h0);
    wr(6'h20, 32'h0000FFFF);
  endtask
  task automatic t_slave;
    fork
      u_spi_far_master.frame(4);
      begin
        step(8);
        rd(6'h30);
        chk("busy", rv, 32'h1);
      end
    join
    step(4);
    rd(6'h30);
    chk("busy", rv, 32'h0);
    rd(6'h20);
    chk("ssev", rv & 32'h230, 32'h230);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    step(16);
    i_rst_n <= 1'b1;
    step(1);
    t_reset;
    t_tx;
    t_rx;
    t_err;
    t_master;
    t_slave;
    finish_test;
  end
  initial begin
    #100000;
    n_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
